// ===== core/psc_consts.vh
// Register map, field positions and reset values of the proximity sense control block
`ifndef PSC_CONSTS_VH
`define PSC_CONSTS_VH
// ****************************************
// Register word indices (byte address = 4 x index)
// ****************************************
`define PSC_IDX_SW_A        4'h0
`define PSC_IDX_SW_B        4'h1
`define PSC_IDX_SW_C        4'h2
`define PSC_IDX_SW_D        4'h3
`define PSC_IDX_SW_E        4'h4
`define PSC_IDX_MAIN        4'h5
`define PSC_IDX_TUNE        4'h6
`define PSC_IDX_DAC         4'h7
`define PSC_IDX_AMP0_CAL    4'h8
`define PSC_IDX_AMP1_CAL    4'h9
`define PSC_IDX_CMP_CAL     4'ha
// ****************************************
// Reset values
// ****************************************
`define PSC_RST_SW          8'h00
`define PSC_RST_MAIN        8'h00
`define PSC_RST_TUNE        6'h00
`define PSC_RST_DAC         8'h00
`define PSC_RST_AMP_CAL     8'h20
`define PSC_RST_CMP_CAL     7'h10
// ****************************************
// Main control fields
// ****************************************
`define PSC_MAIN_AMP1_EN    7
`define PSC_MAIN_AMP0_EN    6
`define PSC_MAIN_CMP_EN     5
`define PSC_MAIN_EDGE_HI    4
`define PSC_MAIN_EDGE_LO    3
`define PSC_MAIN_DEB_HI     2
`define PSC_MAIN_DEB_LO     0
// ****************************************
// Edge select codes
// ****************************************
`define PSC_EDGE_OFF        2'h0
`define PSC_EDGE_RISE       2'h1
`define PSC_EDGE_FALL       2'h2
`define PSC_EDGE_BOTH       2'h3
// ****************************************
// Debounce counter width
// ****************************************
`define PSC_DEB_CNT_W       7
`endif

// ===== core/psc_proximity_sense_control.v
// Register bank, debounce filter and edge interrupt of the proximity sense front end
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`include "psc_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module psc_proximity_sense_control (
  input  wire        core_clk,             // System clock, 250 MHz
  input  wire        rst_n,                // Asynchronous reset, active low
  input  wire [3:0]  avs_address,          // Word address
  input  wire        avs_read,             // Read request
  input  wire        avs_write,            // Write request
  input  wire [31:0] avs_writedata,        // Write data
  input  wire [3:0]  avs_byteenable,       // Byte enables
  output reg  [31:0] avs_readdata,         // Read data
  output reg         avs_waitrequest,      // Stall, high until answer
  input  wire        comparator_result,    // Raw comparator output, asynchronous
  input  wire        amp0_cal_output,      // Amp0 output level in calibration
  input  wire        amp1_cal_output,      // Amp1 output level in calibration
  output reg  [39:0] front_end_switch,     // Analog switch closures, 1 = on
  output reg  [17:0] stage0_switch,        // Stage one switches 0..16 and 39
  output reg  [18:0] stage1_switch,        // Stage two switches 17..35
  output reg  [5:0]  stage0_gain_switch,   // Stage one gain switches 1..6
  output reg  [5:0]  stage1_gain_switch,   // Stage two gain switches 17..22
  output reg         amp0_enable,          // Amp0 on, drives its output pin
  output reg         amp1_enable,          // Amp1 on, drives its output pin
  output reg         amp0_output_pin,      // Route amp0 to its pin
  output reg         amp1_output_pin,      // Route amp1 to its pin
  output reg         amp0_to_adc,          // Offer amp0 to ADC selection
  output reg         amp1_to_adc,          // Offer amp1 to ADC selection
  output reg         comparator_dac_enable,// Comparator and DAC on
  output reg  [7:0]  dac_code,             // Reference DAC code
  output reg  [1:0]  hysteresis_select,    // Comparator hysteresis window
  output reg  [1:0]  bias_current_select,  // Comparator bias current
  output reg         amp0_bandwidth_select,// Amp0 high bandwidth
  output reg         amp1_bandwidth_select,// Amp1 high bandwidth
  output reg  [7:0]  amp0_cal,             // Amp0 cal mode, ref select, trim
  output reg  [7:0]  amp1_cal,             // Amp1 cal mode, ref select, trim
  output reg  [6:0]  comparator_cal,       // Comparator cal mode, ref select, trim
  output reg         filtered_comparator_result, // Debounced comparator level
  output reg         sense_irq             // Interrupt request, one-clock pulse
);
  // ****************************************
  // Registers
  // ****************************************
  reg [7:0]  sw_reg [0:4];
  reg [7:0]  main_ctrl;
  reg [5:0]  tune;
  reg [7:0]  dac_reg;
  reg [7:0]  cal0;
  reg [7:0]  cal1;
  reg [6:0]  calc;
  reg        bus_ack;
  reg [1:0]  cmp_sync;
  reg [1:0]  cal0_sync;
  reg [1:0]  cal1_sync;
  reg [`PSC_DEB_CNT_W-1:0] deb_cnt;
  reg        filt_prev;
  reg [31:0] next_readdata;
  reg        next_filt;
  reg [`PSC_DEB_CNT_W-1:0] next_cnt;
  wire       access   = (avs_read | avs_write) & ~bus_ack;
  wire       wr_lane0 = avs_write & avs_byteenable[0] & ~bus_ack;
  wire       cmp_en   = main_ctrl[`PSC_MAIN_CMP_EN];
  wire [1:0] edge_sel = main_ctrl[`PSC_MAIN_EDGE_HI:`PSC_MAIN_EDGE_LO];
  wire [2:0] deb_sel  = main_ctrl[`PSC_MAIN_DEB_HI:`PSC_MAIN_DEB_LO];
  wire       cmp_live = cmp_sync[1] & cmp_en;
  wire [39:0] sw_all  = {sw_reg[4], sw_reg[3], sw_reg[2], sw_reg[1], sw_reg[0]};
  integer i;

  // Stable-clock threshold for a debounce code: 2^n - 1 extra clocks
  function [`PSC_DEB_CNT_W-1:0] deb_limit;
    input [2:0] code;
    begin
      deb_limit = (7'h01 << code) - 7'h01;
    end
  endfunction

  // ****************************************
  // Avalon-MM slave, one wait cycle per access
  // ****************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack         <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      bus_ack         <= access;
      avs_waitrequest <= ~access;
      avs_readdata    <= access ? next_readdata : 32'h0;
    end
  end

  // ****************************************
  // Register writes, low byte lane only
  // ****************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 5; i = i + 1) begin
        sw_reg[i] <= `PSC_RST_SW;
      end
      main_ctrl       <= `PSC_RST_MAIN;
      tune            <= `PSC_RST_TUNE;
      dac_reg         <= `PSC_RST_DAC;
      cal0            <= `PSC_RST_AMP_CAL;
      cal1            <= `PSC_RST_AMP_CAL;
      calc            <= `PSC_RST_CMP_CAL;
    end else begin
      if (wr_lane0) begin
        case (avs_address)
          `PSC_IDX_SW_A,
          `PSC_IDX_SW_B,
          `PSC_IDX_SW_C,
          `PSC_IDX_SW_D,
          `PSC_IDX_SW_E: sw_reg[avs_address[2:0]] <= avs_writedata[7:0];
          `PSC_IDX_MAIN: main_ctrl <= avs_writedata[7:0];
          `PSC_IDX_TUNE: tune <= avs_writedata[5:0];
          `PSC_IDX_DAC: dac_reg <= avs_writedata[7:0];
          `PSC_IDX_AMP0_CAL: cal0 <= avs_writedata[7:0];
          `PSC_IDX_AMP1_CAL: cal1 <= avs_writedata[7:0];
          `PSC_IDX_CMP_CAL: calc <= avs_writedata[6:0];
          default: ;
        endcase
      end
    end
  end

  // Read mux; unmapped words read zero
  always @* begin
    next_readdata = 32'h0;
    case (avs_address)
      `PSC_IDX_SW_A,
      `PSC_IDX_SW_B,
      `PSC_IDX_SW_C,
      `PSC_IDX_SW_D,
      `PSC_IDX_SW_E: next_readdata[7:0] = sw_reg[avs_address[2:0]];
      `PSC_IDX_MAIN: next_readdata[7:0] = main_ctrl;
      `PSC_IDX_TUNE: next_readdata[7:0] = {cal1_sync[1], cal0_sync[1], tune};
      `PSC_IDX_DAC: next_readdata[7:0] = dac_reg;
      `PSC_IDX_AMP0_CAL: next_readdata[7:0] = cal0;
      `PSC_IDX_AMP1_CAL: next_readdata[7:0] = cal1;
      `PSC_IDX_CMP_CAL: next_readdata[7:0] = {cmp_live, calc};
      default: next_readdata = 32'h0;
    endcase
  end

  // ****************************************
  // Synchronisers and debounce filter
  // ****************************************
  always @* begin
    next_filt = filtered_comparator_result;
    next_cnt  = 7'h00;
    if (deb_sel == 3'h0) begin
      next_filt = cmp_live;
    end else if (cmp_live != filtered_comparator_result) begin
      if (deb_cnt >= deb_limit(deb_sel)) begin
        next_filt = cmp_live;
      end else begin
        next_cnt = deb_cnt + 7'h01;
      end
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_sync                   <= 2'h0;
      cal0_sync                  <= 2'h0;
      cal1_sync                  <= 2'h0;
      deb_cnt                    <= 7'h00;
      filtered_comparator_result <= 1'b0;
    end else begin
      cmp_sync                   <= {cmp_sync[0], comparator_result};
      cal0_sync                  <= {cal0_sync[0], amp0_cal_output};
      cal1_sync                  <= {cal1_sync[0], amp1_cal_output};
      deb_cnt                    <= next_cnt;
      filtered_comparator_result <= next_filt;
    end
  end

  // ****************************************
  // Edge interrupt, one clock per selected edge
  // ****************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_prev <= 1'b0;
      sense_irq <= 1'b0;
    end else begin
      filt_prev <= filtered_comparator_result;
      case (edge_sel)
        `PSC_EDGE_RISE: sense_irq <= filtered_comparator_result & ~filt_prev;
        `PSC_EDGE_FALL: sense_irq <= ~filtered_comparator_result & filt_prev;
        `PSC_EDGE_BOTH: sense_irq <= filtered_comparator_result ^ filt_prev;
        default: sense_irq <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // Switch outputs, registered
  // ****************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      front_end_switch   <= 40'h0;
      stage0_switch      <= 18'h0;
      stage1_switch      <= 19'h0;
      stage0_gain_switch <= 6'h0;
      stage1_gain_switch <= 6'h0;
    end else begin
      front_end_switch   <= sw_all;
      stage0_switch      <= {sw_all[39], sw_all[16:0]};
      stage1_switch      <= sw_all[35:17];
      stage0_gain_switch <= sw_all[6:1];
      stage1_gain_switch <= sw_all[22:17];
    end
  end

  // ****************************************
  // Amplifier controls, registered
  // ****************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      amp0_enable           <= 1'b0;
      amp1_enable           <= 1'b0;
      amp0_output_pin       <= 1'b0;
      amp1_output_pin       <= 1'b0;
      amp0_to_adc           <= 1'b0;
      amp1_to_adc           <= 1'b0;
      amp0_bandwidth_select <= 1'b0;
      amp1_bandwidth_select <= 1'b0;
    end else begin
      amp0_enable           <= main_ctrl[`PSC_MAIN_AMP0_EN];
      amp1_enable           <= main_ctrl[`PSC_MAIN_AMP1_EN];
      amp0_output_pin       <= main_ctrl[`PSC_MAIN_AMP0_EN];
      amp1_output_pin       <= main_ctrl[`PSC_MAIN_AMP1_EN];
      amp0_to_adc           <= main_ctrl[`PSC_MAIN_AMP0_EN];
      amp1_to_adc           <= main_ctrl[`PSC_MAIN_AMP1_EN];
      amp1_bandwidth_select <= tune[1];
      amp0_bandwidth_select <= tune[0];
    end
  end

  // ****************************************
  // Comparator and DAC controls, registered
  // ****************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      comparator_dac_enable <= 1'b0;
      dac_code              <= 8'h00;
      hysteresis_select     <= 2'h0;
      bias_current_select   <= 2'h0;
    end else begin
      comparator_dac_enable <= cmp_en;
      dac_code              <= dac_reg;
      hysteresis_select     <= tune[5:4];
      bias_current_select   <= tune[3:2];
    end
  end

  // ****************************************
  // Calibration controls, registered
  // ****************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      amp0_cal       <= `PSC_RST_AMP_CAL;
      amp1_cal       <= `PSC_RST_AMP_CAL;
      comparator_cal <= `PSC_RST_CMP_CAL;
    end else begin
      amp0_cal       <= cal0;
      amp1_cal       <= cal1;
      comparator_cal <= calc;
    end
  end
endmodule // psc_proximity_sense_control
`default_nettype wire

// ===== testbench/psc_analog_model.sv
// Behavioural model of the amplifiers, comparator and reference DAC
`timescale 1ns/100ps
`default_nettype none
module psc_analog_model (
  input  wire logic [7:0] sense_level,           // Amplified input level
  input  wire logic       comparator_dac_enable, // Comparator and DAC on
  input  wire logic [7:0] dac_code,              // Reference code
  input  wire logic [7:0] amp0_cal,              // Amp0 calibration
  input  wire logic [7:0] amp1_cal,              // Amp1 calibration
  output var  logic       comparator_result,     // Raw comparator
  output var  logic       amp0_cal_output,       // Amp0 calibration level
  output var  logic       amp1_cal_output        // Amp1 calibration level
);
  assign comparator_result = comparator_dac_enable && (sense_level > dac_code);
  assign amp0_cal_output = amp0_cal[7] && (amp0_cal[5:0] > 6'h20);
  assign amp1_cal_output = amp1_cal[7] && (amp1_cal[5:0] > 6'h20);
endmodule // psc_analog_model
`default_nettype wire

// ===== testbench/psc_checker_assertions.sv
// Port checks of the proximity sense control block
`timescale 1ns/100ps
`default_nettype none
module psc_checker (
  input wire logic        core_clk,        // Clock
  input wire logic        rst_n,           // Reset, active low
  input wire logic        avs_read,        // Read
  input wire logic        avs_write,       // Write
  input wire logic        avs_waitrequest, // Stall
  input wire logic [31:0] avs_readdata,    // Read data
  input wire logic [39:0] front_end_switch,   // Switches
  input wire logic [17:0] stage0_switch,      // Stage one
  input wire logic [18:0] stage1_switch,      // Stage two
  input wire logic [5:0]  stage0_gain_switch, // Gain one
  input wire logic [5:0]  stage1_gain_switch, // Gain two
  input wire logic        amp0_enable,     // Amp0 on
  input wire logic        amp0_output_pin, // Amp0 pin
  input wire logic        amp0_to_adc,     // Amp0 to ADC
  input wire logic        filtered_comparator_result, // Filtered
  input wire logic        sense_irq        // Interrupt
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_stage0; stage0_switch == {front_end_switch[39], front_end_switch[16:0]}; endproperty
  a_stage0: assert property (p_stage0) else $error("stage one switches wrong");
  property p_stage1; stage1_switch == front_end_switch[35:17]; endproperty
  a_stage1: assert property (p_stage1) else $error("stage two switches wrong");
  property p_gain;
    stage0_gain_switch == front_end_switch[6:1] && stage1_gain_switch == front_end_switch[22:17];
  endproperty
  a_gain: assert property (p_gain) else $error("gain switches wrong");
  property p_route; amp0_output_pin == amp0_enable && amp0_to_adc == amp0_enable; endproperty
  a_route: assert property (p_route) else $error("amp0 routing wrong");
  property p_sw_write; $changed(front_end_switch) |-> $past(avs_write && !avs_waitrequest); endproperty
  a_sw_write: assert property (p_sw_write) else $error("switch change without write");
  property p_ack; (avs_read || avs_write) && avs_waitrequest |-> ##[1:3] !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("access not answered");
  property p_idle_zero; avs_waitrequest |-> avs_readdata == 32'h0; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data while stalled");
  property p_irq_pulse; sense_irq |=> !sense_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one clock");
  property p_irq_cause;
    sense_irq |-> $past(filtered_comparator_result) != $past(filtered_comparator_result, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without edge");
  c_irq: cover property (sense_irq);
  c_rise: cover property ($rose(filtered_comparator_result));
  c_write: cover property (avs_write && !avs_waitrequest);
endmodule // psc_checker
bind psc_proximity_sense_control psc_checker psc_checker_inst (
  .core_clk(core_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
  .front_end_switch(front_end_switch), .stage0_switch(stage0_switch),
  .stage1_switch(stage1_switch), .stage0_gain_switch(stage0_gain_switch),
  .stage1_gain_switch(stage1_gain_switch), .amp0_enable(amp0_enable),
  .amp0_output_pin(amp0_output_pin), .amp0_to_adc(amp0_to_adc),
  .filtered_comparator_result(filtered_comparator_result), .sense_irq(sense_irq));
`default_nettype wire

// ===== testbench/psc_proximity_sense_control_tb.sv
// Self-checking bench of the proximity sense control block
`timescale 1ns/100ps
`default_nettype none
module psc_proximity_sense_control_tb;
  logic core_clk, rst_n, avs_read, avs_write;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, rd;
  logic [7:0] sense_level;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, comparator_result, amp0_cal_output, amp1_cal_output;
  wire [39:0] front_end_switch;
  wire [17:0] stage0_switch;
  wire [18:0] stage1_switch;
  wire [5:0] stage0_gain_switch, stage1_gain_switch;
  wire amp0_enable, amp1_enable, amp0_output_pin, amp1_output_pin, amp0_to_adc, amp1_to_adc;
  wire comparator_dac_enable, amp0_bandwidth_select, amp1_bandwidth_select;
  wire filtered_comparator_result, sense_irq;
  wire [7:0] dac_code, amp0_cal, amp1_cal;
  wire [6:0] comparator_cal;
  wire [1:0] hysteresis_select, bias_current_select;
  integer err_total, checks, i, c;
  // Rows: index, value read before the write, value written, value read back
  logic [27:0] rows [0:12] = '{28'h0008181, 28'h1004242, 28'h2003c3c, 28'h300a5a5,
    28'h4009696, 28'h600ff3f, 28'h7008080, 28'h820ffff, 28'h920ffff, 28'ha10ff7f,
    28'h6ff2ded, 28'hb00ff00, 28'h500e0e0};
  psc_proximity_sense_control psc_proximity_sense_control_inst (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .comparator_result(comparator_result), .amp0_cal_output(amp0_cal_output),
    .amp1_cal_output(amp1_cal_output), .front_end_switch(front_end_switch),
    .stage0_switch(stage0_switch), .stage1_switch(stage1_switch),
    .stage0_gain_switch(stage0_gain_switch), .stage1_gain_switch(stage1_gain_switch),
    .amp0_enable(amp0_enable), .amp1_enable(amp1_enable), .amp0_output_pin(amp0_output_pin),
    .amp1_output_pin(amp1_output_pin), .amp0_to_adc(amp0_to_adc), .amp1_to_adc(amp1_to_adc),
    .comparator_dac_enable(comparator_dac_enable), .dac_code(dac_code),
    .hysteresis_select(hysteresis_select), .bias_current_select(bias_current_select),
    .amp0_bandwidth_select(amp0_bandwidth_select), .amp1_bandwidth_select(amp1_bandwidth_select),
    .amp0_cal(amp0_cal), .amp1_cal(amp1_cal), .comparator_cal(comparator_cal),
    .filtered_comparator_result(filtered_comparator_result), .sense_irq(sense_irq));
  psc_analog_model psc_analog_model_inst (
    .sense_level(sense_level), .comparator_dac_enable(comparator_dac_enable),
    .dac_code(dac_code), .amp0_cal(amp0_cal), .amp1_cal(amp1_cal),
    .comparator_result(comparator_result), .amp0_cal_output(amp0_cal_output),
    .amp1_cal_output(amp1_cal_output));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ********
  // Tasks
  // ********
  task test_done;
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp_reg(input [31:0] e, input [31:0] g);
    checks = checks + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task cmp_pin(input [39:0] e, input [39:0] g);
    checks = checks + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task av(input [3:0] a, input w, input [7:0] d, input [3:0] be);
    integer n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      n = n + 1;
      if (n > 20) begin
        err_total = err_total + 1;
        test_done;
      end
      @(posedge core_clk);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task watch(input integer n);
    c = 0;
    repeat (n) begin
      @(posedge core_clk);
      if (sense_irq === 1'b1) c = c + 1;
    end
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    err_total = 0;
    checks = 0;
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    sense_level = 8'h00;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 13; i = i + 1) begin
      av(rows[i][27:24], 1'b0, 8'h00, 4'hf);
      cmp_reg({24'h0, rows[i][23:16]}, rd);
      av(rows[i][27:24], 1'b1, rows[i][15:8], 4'hf);
      av(rows[i][27:24], 1'b0, 8'h00, 4'hf);
      cmp_reg({24'h0, rows[i][7:0]}, rd);
    end
    cmp_pin(40'h96a53c4281, front_end_switch);
    cmp_pin({3'h0, 18'h24281, 19'h3529e}, {3'h0, stage0_switch, stage1_switch});
    cmp_pin({28'h0, 6'h00, 6'h1e}, {28'h0, stage0_gain_switch, stage1_gain_switch});
    cmp_pin(40'h80, {32'h0, dac_code});
    cmp_pin(40'h2d, {34'h0, hysteresis_select, bias_current_select,
      amp1_bandwidth_select, amp0_bandwidth_select});
    cmp_pin(40'h7, {37'h0, amp1_enable, amp0_enable, comparator_dac_enable});
    cmp_pin(40'hf, {36'h0, amp1_output_pin, amp1_to_adc, amp0_output_pin, amp0_to_adc});
    cmp_pin(40'h7fffff, {17'h0, amp0_cal, amp1_cal, comparator_cal});
    av(4'h0, 1'b1, 8'h00, 4'he);
    av(4'h0, 1'b0, 8'h00, 4'hf);
    cmp_reg(32'h81, rd);
    for (i = 0; i < 4; i = i + 1) begin
      av(4'h5, 1'b1, {3'b001, i[1:0], 3'b000}, 4'hf);
      @(posedge core_clk) sense_level <= 8'hff;
      watch(10);
      cmp_reg({31'h0, i[0]}, c);
      @(posedge core_clk) sense_level <= 8'h00;
      watch(10);
      cmp_reg({31'h0, i[1]}, c);
    end
    for (i = 3; i < 8; i = i + 4) begin
      av(4'h5, 1'b1, {5'b00100, i[2:0]}, 4'hf);
      @(posedge core_clk) sense_level <= 8'hff;
      watch((1 << i) - 2);
      cmp_pin(40'h0, {39'h0, filtered_comparator_result});
      watch(10);
      cmp_pin(40'h1, {39'h0, filtered_comparator_result});
      @(posedge core_clk) sense_level <= 8'h00;
      watch((1 << i) + 10);
    end
    av(4'h5, 1'b1, 8'h3b, 4'hf);
    @(posedge core_clk) sense_level <= 8'hff;
    repeat (4) @(posedge core_clk);
    sense_level <= 8'h00;
    watch(20);
    cmp_reg(32'h0, c);
    av(4'h5, 1'b1, 8'h30, 4'hf);
    @(posedge core_clk) sense_level <= 8'hff;
    watch(10);
    av(4'ha, 1'b0, 8'h00, 4'hf);
    cmp_reg(32'hff, rd);
    av(4'h5, 1'b1, 8'h10, 4'hf);
    watch(10);
    cmp_reg(32'h1, c);
    cmp_pin(40'h0, {39'h0, filtered_comparator_result});
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    cmp_pin(40'h0, front_end_switch);
    rst_n <= 1'b1;
    av(4'h8, 1'b0, 8'h00, 4'hf);
    cmp_reg(32'h20, rd);
    test_done;
  end
endmodule // psc_proximity_sense_control_tb
`default_nettype wire
